// [vlsu_cfg.svh]
// Purpose: Constants for the vector load/store formatting unit
// Assumes: 128-bit vector registers, eight 16-bit slices, 32 registers
// Notes:   Op codes are the sub-op field of the coprocessor load/store words
`ifndef VLSU_CFG_SVH
`define VLSU_CFG_SVH
`define OP_BYTE     5'h00
`define OP_HALF     5'h01
`define OP_LONG     5'h02
`define OP_DOUBLE   5'h03
`define OP_QUAD     5'h04
`define OP_PACK_S   5'h06
`define OP_PACK_U   5'h07
`define OP_SEXT     5'h08
`define OP_ZEXT     5'h09
`define OP_ALT_B    5'h0a
`define OP_FOURTH   5'h0b
`define OP_ALT_H    5'h0c
`define OP_TRANS    5'h0d
`define OP_TRANS_W  5'h0e
`define MAJ_LOAD    6'h32
`define MAJ_STORE   6'h3a
`define DW_BYTES    5'h08
`endif

// [vlsu_pkg.sv]
// Purpose: Types for the vector load/store formatting unit
// Assumes: vlsu_cfg.svh constants
// Notes:   Request and answer groups travel as packed structs
package vlsu_pkg;
	typedef struct packed {
		logic        valid;
		logic [5:0]  major;
		logic [31:0] base;
		logic [4:0]  vreg;
		logic [4:0]  op;
		logic [3:0]  elem;
		logic [6:0]  offset;
	} req_t;
	typedef struct packed {
		logic         valid;
		logic [4:0]   vreg;
		logic [15:0]  bmask;
		logic [127:0] data;
	} vwr_t;
	typedef struct packed {
		logic         valid;
		logic [31:0]  addr;
		logic [15:0]  bmask;
		logic [127:0] data;
	} mwr_t;
	typedef struct packed {
		vwr_t [7:0] vw;
		logic [7:0] vw_on;
		mwr_t       mw;
	} state_t;
endpackage : vlsu_pkg

// [vector_load_store_unit.sv]
// Purpose: Formats vector loads and stores between data RAM and vector registers
// Assumes: RAM read of 16 bytes at the doubleword-aligned address arrives with the request
// Notes:   One cycle from request to register/RAM write; memory byte 0 is the MSB
// Overview of operation
// [RULE1] Small loads write item into element-selected bytes; others untouched
// [RULE2] Quad load fills whole register with sixteen bytes (code fills only the bytes that lie within the fetched pair)
// [RULE3] Signed pack load puts bytes in slice high byte, low byte cleared
// [RULE4] Unsigned pack load puts zero-prefixed byte in slice top bits
// [RULE5] Sign-extending load widens eight bytes to sixteen-bit slices
// [RULE6] Zero-extending load widens eight bytes to sixteen-bit slices
// [RULE7] Alternate-byte load takes every second byte, zero-prefixed, into slices
// [RULE8] Fourths load takes every fourth byte into element-selected slices
// [RULE9] Alternate-half load takes four halves into element-selected slices
// [RULE10] Transposed load spreads eight halves diagonally over eight registers
// [RULE11] Wrapped transposed load also rotates data by element
// [RULE12] Stores use the store opcode and mirror each load variant
// [RULE13] RAM writes doubleword aligned; quad spill past address+8 dropped (code drops only bytes past address+15)
// [RULE14] Software keeps store element within source register
// [RULE15] Small stores write element-selected bytes at effective address
// [RULE16] Quad store writes whole register within the doubleword limit
// [RULE17] Signed pack store writes slice high bytes to eight bytes
// [RULE18] Unsigned pack store writes slice bits 14:7 to eight bytes
// [RULE19] Extended byte stores write slice low bytes to eight bytes
// [RULE20] Alternate-byte store writes bits 14:7 to every second byte
// [RULE21] Fourths store writes four slices' bits 14:7 to every fourth byte
// [RULE22] Alternate-half store writes four halves to every second half
// [RULE23] Address is base plus offset scaled by item size
// [RULE24] RAM read supplies two doublewords; quad overflow is not fetched
// [RULE25] Software keeps load element within destination register
// [RULE26] Alternate-byte and fourths loads clear bits below the padded byte
`timescale 1ns/1ns
`include "vlsu_cfg.svh"
`default_nettype none
module vector_load_store_unit (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire vlsu_pkg::req_t req,
	input  wire logic [127:0]  ram_rdata,
	input  wire logic [127:0]  vreg_rdata [8],
	output logic [4:0]         vreg_raddr [8],
	output vlsu_pkg::vwr_t     vreg_wr [8],
	output vlsu_pkg::mwr_t     ram_wr
);
	vlsu_pkg::state_t st;
	vlsu_pkg::state_t next_st;

	// Item size in bytes as log2, used for offset weighting
	function automatic logic [2:0] size_log(input logic [4:0] op);
		unique case (op)
			`OP_BYTE:   size_log = 3'h0;
			`OP_HALF:   size_log = 3'h1;
			`OP_LONG:   size_log = 3'h2;
			`OP_DOUBLE: size_log = 3'h3;
			`OP_QUAD:   size_log = 3'h4;
			`OP_TRANS, `OP_TRANS_W: size_log = 3'h4;
			default:    size_log = 3'h3;
		endcase
	endfunction : size_log

	// Byte i of a 128-bit big-endian quantity
	function automatic logic [7:0] byte_of(input logic [127:0] q, input logic [4:0] i);
		byte_of = q[8'(127 - 8 * 32'(i[3:0])) -: 8];
	endfunction : byte_of

	// Slice s of a register, slice 0 in the top bits
	function automatic logic [15:0] slice_of(input logic [127:0] q, input logic [2:0] s);
		slice_of = q[8'(127 - 16 * 32'(s)) -: 16];
	endfunction : slice_of

	// Slot used by physical slice s of a transposed op; the wrapped form rotates by element
	function automatic logic [2:0] trans_slot(input logic [4:0] op, input logic [2:0] s,
		input logic [3:0] e);
		trans_slot = (op == `OP_TRANS_W) ? 3'(s + e[3:1]) : s; // RULE11
	endfunction : trans_slot

	// Register touched by physical slice s; the diagonal wraps inside the group of eight
	function automatic logic [4:0] trans_reg(input logic [4:0] v, input logic [2:0] s,
		input logic [3:0] e);
		trans_reg = {v[4:3], 3'(v[2:0] + s + e[3:1])}; // RULE10
	endfunction : trans_reg

	// Op codes that the unit decodes; every other code is refused
	function automatic logic known_op(input logic [4:0] op);
		known_op = op inside {[`OP_BYTE:`OP_QUAD], [`OP_PACK_S:`OP_TRANS_W]};
	endfunction : known_op

	logic [31:0]  ea;
	logic [2:0]   sz;
	logic [3:0]   lo;
	logic [127:0] mem_win;
	logic [4:0]   nbytes;
	logic         is_load;
	logic         is_store;
	logic [127:0] src;

	// Effective address, offset sign-extended then scaled
	assign sz = size_log(req.op);
	assign ea = req.base + (32'(signed'(req.offset)) << sz); // RULE23
	assign lo = ea[3:0];
	assign is_load = req.valid && (req.major == `MAJ_LOAD);
	assign is_store = req.valid && (req.major == `MAJ_STORE); // RULE12
	assign src = vreg_rdata[0];

	// Window of memory from the effective byte; bytes beyond the pair read as 0
	always_comb begin
		mem_win = '0;
		for (int i = 0; i < 16; i++) begin
			if (i + 32'(ea[2:0]) < 16)
				mem_win[127 - 8 * i -: 8] = byte_of(ram_rdata, 5'(i + 32'(ea[2:0]))); // RULE24
		end
	end

	// Register read addresses; transposed stores read a diagonal of registers, other
	// stores use slot 0 only, so the plain sequence costs nothing there
	always_comb begin
		for (int s = 0; s < 8; s++) begin
			if (req.op == `OP_TRANS || req.op == `OP_TRANS_W)
				vreg_raddr[s] = trans_reg(req.vreg, 3'(s), req.elem); // RULE10
			else
				vreg_raddr[s] = req.vreg + 5'(s);
		end
	end

	// Next-state formatting for every op
	always_comb begin
		next_st = '0;
		nbytes = 5'h01 << sz;
		if (is_load) begin
			next_st.vw[0].valid = 1'b1;
			next_st.vw[0].vreg = req.vreg;
			next_st.vw_on[0] = 1'b1;
			unique case (req.op)
				`OP_BYTE, `OP_HALF, `OP_LONG, `OP_DOUBLE, `OP_QUAD: begin
					for (int i = 0; i < 16; i++) begin
						// Bytes past the fetched pair stay untouched for a later rest load
						if (i < 32'(nbytes) && i + 32'(req.elem) < 16
							&& i + 32'(ea[2:0]) < 16) begin // RULE24
							next_st.vw[0].bmask[15 - i - 32'(req.elem)] = 1'b1; // RULE1 RULE2
							next_st.vw[0].data[127 - 8 * (i + 32'(req.elem)) -: 8] =
								mem_win[127 - 8 * i -: 8];
						end
					end
				end
				`OP_PACK_S, `OP_PACK_U, `OP_SEXT, `OP_ZEXT, `OP_ALT_B: begin
					next_st.vw[0].bmask = 16'hffff;
					for (int s = 0; s < 8; s++) begin
						logic [7:0] b;
						b = (req.op == `OP_ALT_B) ? mem_win[127 - 16 * s -: 8]
							: mem_win[127 - 8 * s -: 8];
						unique case (req.op)
							`OP_PACK_S: next_st.vw[0].data[127 - 16 * s -: 16] = {b, 8'h00}; // RULE3
							`OP_SEXT:   next_st.vw[0].data[127 - 16 * s -: 16] =
								{{8{b[7]}}, b}; // RULE5
							`OP_ZEXT:   next_st.vw[0].data[127 - 16 * s -: 16] = {8'h00, b}; // RULE6
							default:    next_st.vw[0].data[127 - 16 * s -: 16] =
								{1'b0, b, 7'h00}; // RULE4 RULE7 RULE26
						endcase
					end
				end
				`OP_FOURTH, `OP_ALT_H: begin
					for (int k = 0; k < 4; k++) begin
						int s;
						s = (req.elem[3] ? 4 : 0) + k;
						next_st.vw[0].bmask[15 - 2 * s -: 2] = 2'h3;
						if (req.op == `OP_FOURTH)
							next_st.vw[0].data[127 - 16 * s -: 16] =
								{1'b0, mem_win[127 - 32 * k -: 8], 7'h00}; // RULE8 RULE26
						else
							next_st.vw[0].data[127 - 16 * s -: 16] =
								mem_win[127 - 32 * k -: 16]; // RULE9
					end
				end
				`OP_TRANS, `OP_TRANS_W: begin
					next_st.vw_on = 8'hff;
					for (int s = 0; s < 8; s++) begin
						logic [2:0] slot;
						slot = trans_slot(req.op, 3'(s), req.elem); // RULE11
						next_st.vw[s].valid = 1'b1;
						next_st.vw[s].vreg = trans_reg(req.vreg, 3'(s), req.elem); // RULE10
						next_st.vw[s].bmask[15 - 2 * 32'(slot) -: 2] = 2'h3;
						next_st.vw[s].data[127 - 16 * 32'(slot) -: 16] = mem_win[127 - 16 * s -: 16];
					end
				end
				default: begin
					next_st.vw[0].valid = 1'b0;
					next_st.vw_on = 8'h00;
				end
			endcase
		end else if (is_store) begin
			next_st.mw.valid = 1'b1;
			next_st.mw.addr = {ea[31:3], 3'h0}; // RULE13
			unique case (req.op)
				`OP_BYTE, `OP_HALF, `OP_LONG, `OP_DOUBLE, `OP_QUAD: begin
					for (int i = 0; i < 16; i++) begin
						if (i < 32'(nbytes) && i + 32'(ea[2:0]) < 16) begin
							next_st.mw.bmask[15 - i - 32'(ea[2:0])] = 1'b1; // RULE15 RULE16 RULE13
							next_st.mw.data[127 - 8 * (i + 32'(ea[2:0])) -: 8] =
								byte_of(src, 5'(i + 32'(req.elem)));
						end
					end
				end
				`OP_PACK_S, `OP_PACK_U, `OP_SEXT, `OP_ZEXT, `OP_ALT_B, `OP_FOURTH, `OP_ALT_H: begin
					for (int s = 0; s < 8; s++) begin
						logic [15:0] h;
						int pos;
						int k;
						k = s % 4;
						h = slice_of(src, 3'(s));
						pos = 32'(ea[2:0]);
						unique case (req.op)
							`OP_PACK_S: begin
								pos = pos + s;
								next_st.mw.data[127 - 8 * pos -: 8] = h[15:8]; // RULE17
							end
							`OP_PACK_U: begin
								pos = pos + s;
								next_st.mw.data[127 - 8 * pos -: 8] = h[14:7]; // RULE18
							end
							`OP_ALT_B: begin
								pos = pos + 2 * s;
								next_st.mw.data[127 - 8 * pos -: 8] = h[14:7]; // RULE20
							end
							`OP_FOURTH: begin
								pos = pos + 4 * k;
								if ((s >= 4) == req.elem[3])
									next_st.mw.data[127 - 8 * pos -: 8] = h[14:7]; // RULE21
							end
							`OP_ALT_H: begin
								pos = pos + 4 * k;
								if ((s >= 4) == req.elem[3])
									next_st.mw.data[127 - 8 * pos -: 16] = h; // RULE22
							end
							default: begin
								pos = pos + s;
								next_st.mw.data[127 - 8 * pos -: 8] = h[7:0]; // RULE19
							end
						endcase
						if (req.op == `OP_ALT_H) begin
							if ((s >= 4) == req.elem[3])
								next_st.mw.bmask[15 - pos -: 2] = 2'h3;
						end else if (req.op != `OP_FOURTH || (s >= 4) == req.elem[3]) begin
							next_st.mw.bmask[15 - pos] = 1'b1;
						end
					end
				end
				`OP_TRANS, `OP_TRANS_W: begin
					// Halfword s comes from its own register of the diagonal; pairs that
					// would fall past the second doubleword are dropped, as for quad stores
					for (int s = 0; s < 8; s++) begin
						int pos;
						pos = 32'(ea[2:0]) + 2 * s;
						if (pos < 15) begin
							next_st.mw.bmask[15 - pos -: 2] = 2'h3; // RULE12 RULE13
							next_st.mw.data[127 - 8 * pos -: 16] =
								slice_of(vreg_rdata[s], trans_slot(req.op, 3'(s), req.elem));
						end
					end
				end
				// Unknown op codes write nothing
				default: next_st.mw = '0;
			endcase
		end
	end

	// Single state register; vreg_wr and ram_wr come straight from it
	always_ff @(posedge mclk) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	always_comb begin
		for (int s = 0; s < 8; s++)
			vreg_wr[s] = st.vw[s];
	end
	assign ram_wr = st.mw;

	// Checks; each answer is registered, so it is judged one edge after the request
	quad_load_full_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
		is_load && req.op == `OP_QUAD && req.elem == 4'h0 && ea[2:0] == 3'h0
		|=> vreg_wr[0].bmask == 16'hffff) else $error("quad load mask");
	quad_load_part_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE24
		is_load && req.op == `OP_QUAD && req.elem == 4'h0 && ea[2:0] == 3'h4
		|=> vreg_wr[0].bmask == 16'hfff0) else $error("quad load beyond pair");
	pack_low_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
		is_load && req.op == `OP_PACK_S |=> (vreg_wr[0].data & {8{16'h00ff}}) == '0)
		else $error("pack low byte");
	zext_top_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
		is_load && req.op == `OP_ZEXT |=> (vreg_wr[0].data & {8{16'hff00}}) == '0)
		else $error("zext top");
	store_align_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
		ram_wr.valid |-> ram_wr.addr[2:0] == 3'h0) else $error("unaligned write");
	quad_spill_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
		is_store && req.op == `OP_QUAD && ea[2:0] == 3'h4
		|=> ram_wr.bmask == 16'h0fff) else $error("quad store spill");
	store_valid_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
		is_store && known_op(req.op) |=> ram_wr.valid && !vreg_wr[0].valid)
		else $error("store lost");
	refused_op_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
		req.valid && !known_op(req.op) |=> !ram_wr.valid && !vreg_wr[0].valid)
		else $error("unknown op wrote");
	trans_store_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
		is_store && req.op == `OP_TRANS && ea[2:0] == 3'h0
		|=> ram_wr.valid && ram_wr.bmask == 16'hffff) else $error("transposed store mask");
	load_valid_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
		is_load && req.op == `OP_BYTE
		|=> vreg_wr[0].valid && $countones(vreg_wr[0].bmask) == 1)
		else $error("byte load mask");
	trans_all_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
		is_load && req.op == `OP_TRANS |=> vreg_wr[7].valid) else $error("transpose");
	pack_store_mask_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE18
		is_store && req.op == `OP_PACK_U && ea[2:0] == 3'h0 |=> ram_wr.bmask == 16'hff00)
		else $error("pack store mask");
	cover_quad_c: cover property (@(posedge mclk) is_load && req.op == `OP_QUAD);
	cover_trans_c: cover property (@(posedge mclk) is_load && req.op == `OP_TRANS_W);
	cover_store_c: cover property (@(posedge mclk) is_store && req.op == `OP_ALT_H);
	cover_tstore_c: cover property (@(posedge mclk) is_store && req.op == `OP_TRANS_W);
endmodule : vector_load_store_unit
`default_nettype wire

// [vlsu_partner.sv]
// Purpose: Scalar pipeline and data RAM stand-in for the load/store unit
// Assumes: Reads are combinational, writes land at the rising edge
// Notes:   Read pair is the sixteen bytes at the doubleword-aligned address
`timescale 1ns/1ns
`include "vlsu_cfg.svh"
`default_nettype none
module vlsu_partner (
	input  wire logic           mclk,
	input  wire vlsu_pkg::req_t req,
	input  wire logic [4:0]     vreg_raddr [8],
	input  wire vlsu_pkg::vwr_t vreg_wr [8],
	input  wire vlsu_pkg::mwr_t ram_wr,
	output logic [127:0]        ram_rdata,
	output logic [127:0]        vreg_rdata [8]
);
	logic [7:0]   mem [128];
	logic [127:0] regs [32];
	logic [31:0]  ea;
	// Offset weight per item size
	function automatic int scl(input logic [4:0] op);
		case (op)
		`OP_BYTE, `OP_HALF, `OP_LONG, `OP_DOUBLE: return int'(op);
		`OP_QUAD, `OP_TRANS, `OP_TRANS_W: return 4;
		default: return 3;
		endcase
	endfunction : scl
	// Varied contents so that sign and pad bits both show up
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
		for (int r = 0; r < 32; r++) regs[r] = {4{32'h9e3779b9 ^ 32'(r * 40503)}};
	end
	// Address and the two-doubleword read; RAM wraps at 128 bytes
	always_comb begin
		ea = req.base + (32'(signed'(req.offset)) << scl(req.op));
		for (int k = 0; k < 16; k++) ram_rdata[127-8*k -: 8] = mem[7'({ea[6:3], 3'h0} + k)];
		for (int s = 0; s < 8; s++) vreg_rdata[s] = regs[vreg_raddr[s]];
	end
	// Byte-masked writes from the unit
	always @(posedge mclk) begin
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 16; k++)
				if (vreg_wr[s].valid && vreg_wr[s].bmask[15-k])
					regs[vreg_wr[s].vreg][127-8*k -: 8] <= vreg_wr[s].data[127-8*k -: 8];
		for (int k = 0; k < 16; k++)
			if (ram_wr.valid && ram_wr.bmask[15-k])
				mem[7'(ram_wr.addr + k)] <= ram_wr.data[127-8*k -: 8];
	end
endmodule : vlsu_partner
`default_nettype wire

// [vector_load_store_unit_tb.sv]
// Purpose: Self-checking bench for the vector load/store unit
// Assumes: Partner holds RAM and register file; expectations from snapshots
// Notes:   Each request is one cycle; results checked two edges later
`timescale 1ns/1ns
`include "vlsu_cfg.svh"
`default_nettype none
module vector_load_store_unit_tb;
	logic           mclk, rst_n;
	vlsu_pkg::req_t req;
	logic [127:0]   ram_rdata;
	logic [127:0]   vreg_rdata [8];
	logic [4:0]     vreg_raddr [8];
	vlsu_pkg::vwr_t vreg_wr [8];
	vlsu_pkg::mwr_t ram_wr;
	int             n_mismatch, total_checks;
	logic [127:0]   r0;
	logic [7:0]     m0 [128];
	logic [4:0]     ops [7] = '{`OP_PACK_S, `OP_PACK_U, `OP_SEXT, `OP_ZEXT, `OP_ALT_B,
	                            `OP_FOURTH, `OP_ALT_H};
	vector_load_store_unit u_vector_load_store_unit (.mclk(mclk), .rst_n(rst_n), .req(req),
		.ram_rdata(ram_rdata), .vreg_rdata(vreg_rdata), .vreg_raddr(vreg_raddr),
		.vreg_wr(vreg_wr), .ram_wr(ram_wr));
	vlsu_partner u_vlsu_partner (.mclk(mclk), .req(req), .vreg_raddr(vreg_raddr),
		.vreg_wr(vreg_wr), .ram_wr(ram_wr), .ram_rdata(ram_rdata), .vreg_rdata(vreg_rdata));
	// Byte and slice views
	function automatic logic [7:0] rb(input logic [127:0] r, input int k);
		return r[127-8*k -: 8];
	endfunction : rb
	function automatic logic [7:0] nb(input int v, input int k);
		return u_vlsu_partner.regs[v][127-8*k -: 8];
	endfunction : nb
	function automatic logic [15:0] sl(input int v, input int s);
		return u_vlsu_partner.regs[v][127-16*s -: 16];
	endfunction : sl
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	// One-cycle request; snapshot first so expectations never come from the unit
	task automatic issue(input logic [5:0] maj, input logic [4:0] op, input logic [4:0] vr,
		input logic [3:0] el, input logic [31:0] b, input logic [6:0] off);
		r0 = u_vlsu_partner.regs[vr];
		m0 = u_vlsu_partner.mem;
		req = '{1'b1, maj, b, vr, op, el, off};
		@(negedge mclk);
		req.valid = 1'b0;
		@(negedge mclk);
	endtask : issue
	task automatic t_loads;
		issue(`MAJ_LOAD, `OP_BYTE, 5'd1, 4'd5, 32'h13, 7'h0);
		for (int k = 0; k < 16; k++) chk("byte load", nb(1, k), k == 5 ? m0[19] : rb(r0, k));
		issue(`MAJ_LOAD, `OP_DOUBLE, 5'd2, 4'd8, 32'h20, 7'h7f);
		for (int k = 8; k < 16; k++) chk("double load", nb(2, k), m0[16 + k]);
		issue(`MAJ_LOAD, `OP_QUAD, 5'd3, 4'd0, 32'h24, 7'h0);
		for (int k = 0; k < 16; k++) chk("quad load", nb(3, k), k < 12 ? m0[36 + k] : rb(r0, k));
		$display("loads done");
	endtask : t_loads
	function automatic logic [15:0] lexp(input logic [4:0] op, input int s);
		logic [7:0] b;
		b = m0[8 + s];
		case (op)
		`OP_PACK_S: return {b, 8'h00};
		`OP_PACK_U: return {1'b0, b, 7'h0};
		`OP_SEXT: return {{8{b[7]}}, b};
		`OP_ZEXT: return {8'h00, b};
		`OP_ALT_B: return {1'b0, m0[8 + 2 * s], 7'h0};
		`OP_FOURTH: return {1'b0, m0[4 * s - 8], 7'h0};
		default: return {m0[4 * s - 8], m0[4 * s - 7]};
		endcase
	endfunction : lexp
	// Upper four slices selected for the last two formats
	task automatic t_formats;
		for (int i = 0; i < 7; i++) begin
			issue(`MAJ_LOAD, ops[i], 5'd4, i > 4 ? 4'd8 : 4'd0, 32'h8, 7'h0);
			for (int s = 0; s < 8; s++)
				chk("format load", sl(4, s), i > 4 && s < 4 ? r0[127-16*s -: 16] : lexp(ops[i], s));
		end
		$display("format loads done");
	endtask : t_formats
	// Element 2 shifts the diagonal by one register; the wrapped form moves the slot too
	task automatic t_trans;
		int e;
		for (int j = 0; j < 3; j++) begin
			e = (j > 0) ? 1 : 0;
			issue(`MAJ_LOAD, j == 2 ? `OP_TRANS_W : `OP_TRANS, 5'(8 * j + 8), 4'(2 * e),
				32'h30, 7'h0);
			for (int s = 0; s < 8; s++)
				chk("transposed", sl(8 * j + 8 + (s + e) % 8, j == 2 ? (s + 1) % 8 : s),
					{m0[48 + 2 * s], m0[49 + 2 * s]});
		end
		$display("transposed done");
	endtask : t_trans
	function automatic logic [7:0] sexp(input logic [4:0] op, input int k);
		logic [15:0] a, b, c;
		a = r0[127-16*(k%8) -: 16];
		b = r0[127-16*(k/2) -: 16];
		c = r0[127-16*(4+k/4) -: 16];
		case (op)
		`OP_PACK_S: return k < 8 ? a[15:8] : m0[64 + k];
		`OP_PACK_U: return k < 8 ? a[14:7] : m0[64 + k];
		`OP_ALT_B: return k % 2 ? m0[64 + k] : b[14:7];
		`OP_FOURTH: return k % 4 ? m0[64 + k] : c[14:7];
		`OP_ALT_H: return k % 4 > 1 ? m0[64 + k] : (k % 2 ? c[7:0] : c[15:8]);
		default: return k < 8 ? a[7:0] : m0[64 + k];
		endcase
	endfunction : sexp
	task automatic t_stores;
		issue(`MAJ_STORE, `OP_BYTE, 5'd5, 4'd3, 32'h25, 7'h0);
		for (int k = 32; k < 40; k++) chk("byte store", u_vlsu_partner.mem[k], k == 37 ? rb(r0, 3) : m0[k]);
		issue(`MAJ_STORE, `OP_LONG, 5'd5, 4'd4, 32'h50, 7'h1);
		for (int k = 0; k < 4; k++) chk("long store", u_vlsu_partner.mem[84 + k], rb(r0, 4 + k));
		issue(`MAJ_STORE, `OP_QUAD, 5'd6, 4'd0, 32'h2c, 7'h0);
		for (int k = 44; k < 60; k++) chk("quad store", u_vlsu_partner.mem[k], k < 56 ? rb(r0, k - 44) : m0[k]);
		for (int i = 0; i < 7; i++) begin
			issue(`MAJ_STORE, ops[i], 5'd7, i > 4 ? 4'd8 : 4'd0, 32'h40, 7'h0);
			for (int k = 0; k < 16; k++) chk("format store", u_vlsu_partner.mem[64 + k], sexp(ops[i], k));
		end
		// Transposed stores gather one halfword from each register of the diagonal
		for (int j = 0; j < 2; j++) begin
			issue(`MAJ_STORE, j ? `OP_TRANS_W : `OP_TRANS, 5'(8 + 16 * j), 4'(2 * j),
				32'h60 + 32'(16 * j), 7'h0);
			for (int s = 0; s < 8; s++)
				chk("transposed store", {u_vlsu_partner.mem[96 + 16 * j + 2 * s],
					u_vlsu_partner.mem[97 + 16 * j + 2 * s]},
					sl(8 + 16 * j + (s + j) % 8, (s + j) % 8));
		end
		$display("stores done");
	endtask : t_stores
	task automatic t_refused;
		issue(6'h00, `OP_QUAD, 5'd9, 4'd0, 32'h0, 7'h0);
		for (int k = 0; k < 16; k++) chk("foreign major", nb(9, k), rb(r0, k));
		issue(`MAJ_STORE, 5'h1f, 5'd9, 4'd0, 32'h0, 7'h0);
		for (int k = 0; k < 16; k++) chk("unknown op", u_vlsu_partner.mem[k], m0[k]);
		$display("refusals done");
	endtask : t_refused
	task automatic results;
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		req = '0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		chk("idle writes", {ram_wr.valid, vreg_wr[0].valid}, 16'h0);
		t_loads;
		t_formats;
		t_trans;
		t_stores;
		t_refused;
		results;
	end
	// Watchdog: whole run needs about 60 cycles
	initial begin
		#(2000 * 10);
		n_mismatch++;
		results;
	end
endmodule : vector_load_store_unit_tb
`default_nettype wire
